// ### design/rsv_pkg.sv
// Package with register map, field layout and reset values for sleep select
package rsv_pkg;

  // ==========================================================
  // Register offsets (byte addresses are four times the index)
  localparam logic [7:0] SLEEP_FORCE_OFF_TWO_IDX = 8'h2a;
  localparam logic [7:0] VOLTAGE_SOURCE_SELECT_IDX = 8'h2b;
  localparam logic [7:0] VOLTAGE_SELECT_PIN_MAP_IDX = 8'h2c;
  localparam logic [7:0] SLEEP_REQUEST_CTRL_IDX = 8'h30;
  localparam logic [7:0] SLEEP_STATUS_IDX = 8'h31;
  localparam logic [7:0] BUCK_STATE_IDX = 8'h32;
  localparam logic [7:0] LINREG_STATE_IDX = 8'h33;

  // ==========================================================
  // Field positions in the force-off and voltage-select registers
  localparam int THERMAL_SLEEP_DISABLE_BIT = 7;
  localparam int SLOW_CLOCK_OUT_SLEEP_DISABLE_BIT = 6;
  localparam int BUCK1_SLEEP_FORCE_OFF_BIT = 2;
  localparam int LINREG9_SLEEP_FORCE_OFF_BIT = 0;
  localparam int LINREG_SELECT_LSB = 4;
  localparam int BUCK_SELECT_LSB = 0;

  // ==========================================================
  // Power-on defaults (one-time-programmed set, first variant)
  localparam logic [7:0] SLEEP_FORCE_OFF_TWO_RST = 8'h04;
  localparam logic [7:0] VOLTAGE_SOURCE_SELECT_RST = 8'h00;
  localparam logic [7:0] VOLTAGE_SELECT_PIN_MAP_RST = 8'h50;

  // Sleep outcome of one regulator
  typedef enum logic [1:0] {
    RSV_ACTIVE,
    RSV_LOW_POWER,
    RSV_OFF
  } rsv_state_t;

  // Settings that decide one regulator's sleep outcome
  typedef struct packed {
    logic keepActive;
    logic forceOff;
    logic sleepReq;
  } rsv_cfg_t;

  // AHB-Lite data-phase context
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } rsv_ahb_t;

  localparam int SYNC_STAGES = 2;

endpackage : rsv_pkg

// ### design/rsv_reg_state.sv
// One regulator's sleep outcome decision, registered
`timescale 1ns/100ps
module rsv_reg_state
  import rsv_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire rsv_cfg_t cfg, // Keep, force-off and sleep request
  output rsv_state_t state // Registered outcome
);

  rsv_state_t state_reg;
  rsv_state_t state_next;

  // Outcome table; keep-active beats force-off, only during sleep
  always_comb
  begin
    // (R11) Active outside sleep
    if (!cfg.sleepReq)
      state_next = RSV_ACTIVE;
    // (R3) Keep-active wins
    else if (cfg.keepActive)
      state_next = RSV_ACTIVE;
    // (R2) Force-off gated by keep
    else if (cfg.forceOff)
      state_next = RSV_OFF;
    else
      state_next = RSV_LOW_POWER;
  end

  // (R12) Re-evaluated each cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= RSV_ACTIVE;
    else
      state_reg <= state_next;
  end

  assign state = state_reg;

endmodule : rsv_reg_state

// ### design/rsv_sleep_select.sv
// Sleep-state and voltage-source select register bank with AHB-Lite slave
`timescale 1ns/100ps

// Notes on behaviour
// (R1) Thermal/clock-out keep bit 1 disables in sleep
// (R2) Force-off acts only when keep-active is 0
// (R3) Sleep: low power, active, or off
// (R4) Select bit 0 normal, 1 scaling register
// (R5) Voltage select applies in every outcome
// (R6) Registers take defaults on power-on reset
// (R7) Force-off register bit layout
// (R8) Voltage-select register bit layout
// (R9) Pin-map register: four two-bit fields
// (R10) Map code picks buck scaling pin 1..4
// (R11) Outcomes only while sleep request held
// (R12) Writes immediate; decisions re-evaluated next cycle
module rsv_sleep_select
  import rsv_pkg::*;
#(
  parameter int NUM_BUCK = 4, // Buck converters
  parameter int NUM_MAPPED = 4 // LDOs with pin mapping
)
(
  input wire logic core_clk, // System clock, 25 MHz
  input wire logic rst_b, // Async power-on reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic sleep_pin, // Sleep request pin
  input wire logic [3:0] buck_scaling_select_pin, // Buck scaling pins
  input wire logic [5:0] sleep_keep_active, // Keep bits: buck4..1, ldo10,9
  output logic thermal_sleep_off, // Thermal monitor off now
  output logic slow_clock_out_off, // 32k clock output off now
  output logic [1:0] buck_state [NUM_BUCK], // Buck sleep outcome
  output logic [1:0] linreg_state [2], // LDO10/9 sleep outcome
  output logic [7:0] voltage_source_sel // Effective select, ldo4..1,buck4..1
);

  // Elaboration check: the bit layout serves exactly four of each
  if (NUM_BUCK != 4 || NUM_MAPPED != 4)
  begin : gen_bad_param
    $error("rsv_sleep_select supports only four bucks and four LDOs");
  end

  // The sleep synchroniser shift below is written for two stages
  if (SYNC_STAGES != 2)
  begin : gen_bad_sync
    $error("rsv_sleep_select needs a two-stage synchroniser");
  end

  // ==========================================================
  // Pin synchronisers
  logic [SYNC_STAGES-1:0] sleepSync_reg;
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  logic sleepReq;

  // Two flops before logic reads the sleep and scaling pins (keep bits go in unsynced); the first may go
  // metastable, so nothing but the second flop ever looks at it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleepSync_reg <= '0;
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
    end
    else
    begin
      sleepSync_reg <= {sleepSync_reg[0], sleep_pin};
      pinMeta_reg <= buck_scaling_select_pin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign sleepReq = sleepSync_reg[SYNC_STAGES-1];

  // ==========================================================
  // AHB-Lite slave
  rsv_ahb_t phase_reg;
  rsv_ahb_t phase_next;
  logic [7:0] forceOff_reg;
  logic [7:0] forceOff_next;
  logic [7:0] voltSel_reg;
  logic [7:0] voltSel_next;
  logic [7:0] pinMap_reg;
  logic [7:0] pinMap_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] readByte;
  logic [7:0] buckPacked;
  logic [7:0] linregPacked;
  logic wordAccess;
  logic inWindow;

  // Only aligned whole words inside the decoded window count; anything
  // else would alias onto a register, so it is ignored
  always_comb
  begin
    wordAccess = (hsize == 3'b010) && (haddr[1:0] == 2'b00);
    inWindow = (haddr[31:10] == 22'h000000);
  end

  // Capture the address phase; word index is the byte address over four
  always_comb
  begin
    phase_next.valid = hsel && hready && htrans[1] && wordAccess &&
      inWindow;
    phase_next.write = hwrite;
    phase_next.index = haddr[9:2];
  end

  // Register writes land in the data phase; zero wait states
  // Data trail the address by a cycle, so decode the captured phase
  always_comb
  begin
    forceOff_next = forceOff_reg;
    voltSel_next = voltSel_reg;
    pinMap_next = pinMap_reg;
    if (phase_reg.valid && phase_reg.write)
    begin
      case (phase_reg.index)
        // (R7) Force-off layout
        SLEEP_FORCE_OFF_TWO_IDX: forceOff_next = hwdata[7:0];
        // (R8) Select layout
        VOLTAGE_SOURCE_SELECT_IDX: voltSel_next = hwdata[7:0];
        // (R9) Pin-map fields
        VOLTAGE_SELECT_PIN_MAP_IDX: pinMap_next = hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped reads return zero, status shows live state
  always_comb
  begin
    case (phase_next.index)
      SLEEP_FORCE_OFF_TWO_IDX: readByte = forceOff_next;
      VOLTAGE_SOURCE_SELECT_IDX: readByte = voltSel_next;
      VOLTAGE_SELECT_PIN_MAP_IDX: readByte = pinMap_next;
      SLEEP_REQUEST_CTRL_IDX: readByte = {7'h00, sleepReq};
      SLEEP_STATUS_IDX: readByte = {6'h00, thermal_sleep_off,
                                    slow_clock_out_off};
      BUCK_STATE_IDX: readByte = buckPacked;
      LINREG_STATE_IDX: readByte = linregPacked;
      default: readByte = 8'h00;
    endcase
    rdata_next = (phase_next.valid && !phase_next.write) ?
      {24'h000000, readByte} : 32'h00000000;
  end

  // (R6) Defaults on power-on reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_reg <= '0;
      forceOff_reg <= SLEEP_FORCE_OFF_TWO_RST;
      voltSel_reg <= VOLTAGE_SOURCE_SELECT_RST;
      pinMap_reg <= VOLTAGE_SELECT_PIN_MAP_RST;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      phase_reg <= phase_next;
      forceOff_reg <= forceOff_next;
      voltSel_reg <= voltSel_next;
      pinMap_reg <= pinMap_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;

  // ==========================================================
  // Bus response; zero wait states and always OKAY, yet kept in flops
  // so that no output of the block comes straight from logic
  logic readyOut_reg;
  logic readyOut_next;
  logic respOut_reg;
  logic respOut_next;

  // Every transfer completes at once and never errors
  always_comb
  begin
    readyOut_next = 1'b1;
    respOut_next = 1'b0;
  end

  // Ready stays high through reset so the bus never stalls on us
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readyOut_reg <= 1'b1;
      respOut_reg <= 1'b0;
    end
    else
    begin
      readyOut_reg <= readyOut_next;
      respOut_reg <= respOut_next;
    end
  end

  assign hreadyout = readyOut_reg;
  assign hresp = respOut_reg;

  // ==========================================================
  // Sleep outcome per regulator
  rsv_state_t buckSt [NUM_BUCK];
  rsv_state_t linSt [2];
  rsv_cfg_t buckCfg [NUM_BUCK];
  rsv_cfg_t linCfg [2];

  // Gather each regulator's keep, force-off and synced sleep request
  always_comb
  begin
    for (int b = 0; b < NUM_BUCK; b++)
    begin
      // (R7) Buck bits 5..2
      buckCfg[b].keepActive = sleep_keep_active[2+b];
      // (R2) Buck force-off bits
      buckCfg[b].forceOff = forceOff_reg[BUCK1_SLEEP_FORCE_OFF_BIT+b];
      // (R11) Shared sleep request
      buckCfg[b].sleepReq = sleepReq;
    end
    for (int l = 0; l < 2; l++)
    begin
      // (R7) LDO bits 1..0
      linCfg[l].keepActive = sleep_keep_active[l];
      // (R2) LDO force-off bits
      linCfg[l].forceOff = forceOff_reg[LINREG9_SLEEP_FORCE_OFF_BIT+l];
      linCfg[l].sleepReq = sleepReq;
    end
  end

  // (R3) Per-buck decision
  for (genvar i = 0; i < NUM_BUCK; i++)
  begin : gen_buck
    rsv_reg_state u_state (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .cfg(buckCfg[i]),
      .state(buckSt[i])
    );
    assign buck_state[i] = buckSt[i];
  end

  // (R3) Ninth, tenth LDO decision
  for (genvar j = 0; j < 2; j++)
  begin : gen_linreg
    rsv_reg_state u_state (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .cfg(linCfg[j]),
      .state(linSt[j])
    );
    assign linreg_state[j] = linSt[j];
  end

  // Pack the live outcomes for the read-only status words; the LDO
  // word has only two fields, so its top half reads zero
  always_comb
  begin
    buckPacked = 8'h00;
    linregPacked = 8'h00;
    for (int b = 0; b < NUM_BUCK; b++)
      buckPacked[2*b +: 2] = buckSt[b];
    for (int l = 0; l < 2; l++)
      linregPacked[2*l +: 2] = linSt[l];
  end

  // ==========================================================
  // Thermal and slow clock gating, voltage source selection
  logic thermOff_reg;
  logic thermOff_next;
  logic clkOff_reg;
  logic clkOff_next;
  logic [7:0] voltOut_reg;
  logic [7:0] voltOut_next;
  logic [NUM_MAPPED-1:0] mappedPin;

  // Keep bit set means the function is switched off, and only in sleep
  always_comb
  begin
    // (R1) Off in sleep when 1
    thermOff_next = sleepReq && forceOff_reg[THERMAL_SLEEP_DISABLE_BIT];
    // (R1) Clock output likewise
    clkOff_next = sleepReq &&
      forceOff_reg[SLOW_CLOCK_OUT_SLEEP_DISABLE_BIT];
  end

  // Each LDO follows the synced pin its code names; the map is always
  // in force, so the stored LDO select bits only read back
  always_comb
  begin
    // (R9) Two bits per LDO
    // (R10) Code picks buck pin
    for (int k = 0; k < NUM_MAPPED; k++)
      mappedPin[k] = pinSync_reg[pinMap_reg[2*k +: 2]];
  end

  // Select is independent of sleep outcome, so it holds in every state
  always_comb
  begin
    // (R4) 0 normal, 1 scaling
    // (R8) Buck selects, low half
    voltOut_next = voltSel_reg;
    // (R10) Mapped pins override
    voltOut_next[LINREG_SELECT_LSB +: NUM_MAPPED] = mappedPin;
    // (R5) No gating by sleep state
  end

  // (R12) Registered next cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      thermOff_reg <= 1'b0;
      clkOff_reg <= 1'b0;
      voltOut_reg <= VOLTAGE_SOURCE_SELECT_RST;
    end
    else
    begin
      thermOff_reg <= thermOff_next;
      clkOff_reg <= clkOff_next;
      voltOut_reg <= voltOut_next;
    end
  end

  assign thermal_sleep_off = thermOff_reg;
  assign slow_clock_out_off = clkOff_reg;
  assign voltage_source_sel = voltOut_reg;

endmodule : rsv_sleep_select

// ### test/rsv_sleep_select_sva.sv
// Port checker for the sleep select register bank
`timescale 1ns/100ps
module rsv_sleep_select_sva
  import rsv_pkg::*;
#(
  parameter int NUM_BUCK = 4 // Buck converters
)
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic hsel, // Select
  input wire logic hready, // Bus ready
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic sleep_pin, // Sleep request
  input wire logic [3:0] buck_scaling_select_pin, // Scaling pins
  input wire logic [5:0] sleep_keep_active, // Keep bits
  input wire logic thermal_sleep_off, // Thermal off
  input wire logic [1:0] buck_state [NUM_BUCK], // Buck outcome
  input wire logic [7:0] voltage_source_sel // Effective select
);
  // ==========================================================
  // Port properties; five cycles cover the three-edge sync path
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_READ_IDLE: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  AST_AWAKE_FUNC: assert property ((!sleep_pin)[*5] |->
    !thermal_sleep_off)
    else $error("thermal monitor off while awake");
  AST_AWAKE_ACTIVE: assert property ((!sleep_pin)[*5] |->
    buck_state[0] == 2'd0 && buck_state[NUM_BUCK-1] == 2'd0)
    else $error("regulator not active while awake");
  AST_KEEP: assert property ((sleep_pin && sleep_keep_active[2])[*5] |->
    buck_state[0] == 2'd0)
    else $error("kept regulator left active state");
  AST_RANGE: assert property (buck_state[1] != 2'd3)
    else $error("undefined sleep outcome");
  AST_MAP_HI: assert property ((buck_scaling_select_pin == 4'hf)[*5] |->
    voltage_source_sel[7:4] == 4'hf)
    else $error("mapped select does not follow pins");
endmodule : rsv_sleep_select_sva
bind rsv_sleep_select rsv_sleep_select_sva #(.NUM_BUCK(NUM_BUCK))
  i_rsv_sleep_select_sva (.*);

// ### test/rsv_host.sv
// Host model driving single AHB-Lite word transfers
`timescale 1ns/100ps
module rsv_host
(
  input wire logic core_clk, // Clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel = 1'b0, // Select
  output logic [31:0] haddr = 32'h0, // Address
  output logic [1:0] htrans = 2'b00, // Transfer type
  output logic hwrite = 1'b0, // Write
  output logic [2:0] hsize = 3'b010, // Word size
  output logic [31:0] hwdata = 32'h0 // Write data
);
  // ==========================================================
  // One transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] i,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
    q = hrdata;
    // Released data shows the inverse so a stale copy never matches
    hwdata <= ~d;
  endtask : xfer
endmodule : rsv_host

// ### test/test_rsv_sleep_select.sv
// Self-checking bench for the sleep select register bank
`timescale 1ns/100ps
module test_rsv_sleep_select;
  import rsv_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sleep_pin = 1'b0;
  logic [3:0] buck_scaling_select_pin = 4'h0;
  logic [5:0] sleep_keep_active = 6'h00;
  logic hsel, hwrite, hresp, hreadyout, thermal_sleep_off, slow_clock_out_off;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [1:0] buck_state [4];
  logic [1:0] linreg_state [2];
  logic [7:0] voltage_source_sel;
  wire logic hready;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] rstv [3] = '{SLEEP_FORCE_OFF_TWO_RST,
    VOLTAGE_SOURCE_SELECT_RST, VOLTAGE_SELECT_PIN_MAP_RST};
  logic [1:0] expb [4] = '{2'd0, 2'd2, 2'd0, 2'd1};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  rsv_sleep_select i_rsv_sleep_select (.*);
  rsv_host i_rsv_host (.*);
  // ==========================================================
  // Clock and hang guard
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    i_rsv_host.xfer(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    i_rsv_host.xfer(1'b0, i, 32'h0, q);
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge core_clk);
  endtask : settle
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'h2a + i[7:0]);
      chk("default", {24'h0, rstv[i]}, q);
      wr(8'h2a + i[7:0], 32'ha5);
      rd(8'h2a + i[7:0]);
      chk("rw a5", 32'ha5, q);
      wr(8'h2a + i[7:0], 32'h5a);
      rd(8'h2a + i[7:0]);
      chk("rw 5a", 32'h5a, q);
    end
    wr(8'h3f, 32'hff);
    rd(8'h3f);
    chk("unmapped", 32'h0, q);
    chk("hresp", 1'b0, hresp);
    $display("test registers done");
    // Keep and force-off mix gives every sleep outcome
    wr(8'h2a, 32'hcd);
    wr(8'h2b, 32'h0a);
    sleep_keep_active <= 6'b010110;
    settle();
    chk("awake buck2", RSV_ACTIVE, buck_state[1]);
    chk("awake sel", 4'ha, voltage_source_sel[3:0]);
    sleep_pin <= 1'b1;
    settle();
    chk("thermal", 1'b1, thermal_sleep_off);
    chk("clkout", 1'b1, slow_clock_out_off);
    for (int i = 0; i < 4; i++)
      chk("buck", expb[i], buck_state[i]);
    chk("ldo9", RSV_OFF, linreg_state[0]);
    chk("ldo10", RSV_ACTIVE, linreg_state[1]);
    chk("sleep sel", 4'ha, voltage_source_sel[3:0]);
    wr(8'h2a, 32'h00);
    settle();
    chk("thermal on", 1'b0, thermal_sleep_off);
    chk("buck2 lowpower", RSV_LOW_POWER, buck_state[1]);
    sleep_pin <= 1'b0;
    settle();
    chk("woken buck4", RSV_ACTIVE, buck_state[3]);
    $display("test sleep done");
    // Every map code steers all four LDO selects to one pin
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h2c, {24'h0, {4{c[1:0]}}});
      buck_scaling_select_pin <= 4'h1 << c;
      settle();
      chk("map hit", 4'hf, voltage_source_sel[7:4]);
      buck_scaling_select_pin <= ~(4'h1 << c);
      settle();
      chk("map miss", 4'h0, voltage_source_sel[7:4]);
    end
    buck_scaling_select_pin <= 4'hf;
    settle();
    chk("all pins", 4'hf, voltage_source_sel[7:4]);
    $display("test map done");
    // A second power-on reset must bring back every default
    rst_b <= 1'b0;
    settle();
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'h2a + i[7:0]);
      chk("reset default", {24'h0, rstv[i]}, q);
    end
    $display("test reset done");
    summarize();
  end
endmodule : test_rsv_sleep_select
